// *** hw/vrc_cfg.svh ***
// Purpose: constants of the voice recorder condition command block
// Assumes: 10 MHz system clock, 4-bit host nibble bus
// Notes: every offset, field position, code and timing count lives here, except the gain field and gain codes decoded in the command block
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

// command opcodes (first nibble)
`define VRC_OP_CAPTURE    4'h3
`define VRC_OP_PLAY       4'h2
`define VRC_OP_VOICE      4'h5
`define VRC_OP_RATE_MODE  4'h6
`define VRC_OP_PHRASE     4'h7
`define VRC_OP_HDR_WR     4'h8
`define VRC_OP_HDR_RD     4'h9
`define VRC_OP_BLK_WR     4'hA
`define VRC_OP_STORED_RD  4'hB
`define VRC_OP_LIVE_RD    4'hC
`define VRC_OP_FLAG_WR    4'hD
`define VRC_OP_GAIN       4'hE

// data nibble counts
`define VRC_NIB_SHORT     4'h1
`define VRC_NIB_BYTE      4'h2
`define VRC_NIB_HDR       4'hA

// field positions inside a data nibble
`define VRC_RATE_LSB      0
`define VRC_MODE_LSB      2
`define VRC_FLAG_OPT_BIT  0
`define VRC_FLAG_RSEL_BIT 1

// condition values
`define VRC_RATE_BAD      2'h3
`define VRC_MODE_REC      2'h0
`define VRC_MODE_ROM      2'h1
`define VRC_PHRASE_ZERO   8'h00
`define VRC_PHRASE_RAM_MAX 8'h3F
`define VRC_BLOCK_FIRST   8'h01
`define VRC_BLOCKS_TOTAL  256
`define VRC_VOICE_OFF     4'h0

// timing
`define VRC_CLK_HZ        10000000
`define VRC_T_CMD_NS      16000
`define VRC_T_RDCMD_NS    270000
`define VRC_T_DATA_NS     50000
`define VRC_T_RESET_NS    1000000
`define VRC_CYC(ns) (((ns) * (`VRC_CLK_HZ / 1000000) + 999) / 1000)

`endif

// *** hw/vrc_cmd.sv ***
// Purpose: command interpreter for record/playback conditions
// Assumes: host nibble bus pins asynchronous to clk_sys_i
// Notes: recording data path supplies op_start/op_block/op_end pulses
`timescale 1ns/1ns
`include "vrc_cfg.svh"
module vrc_cmd #(
	parameter int PHRASES         = 64,
	parameter int RESET_BUSY_CYC  = `VRC_CYC(`VRC_T_RESET_NS)
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              por_i,
	input  wire logic [3:0]        nib_i,
	output logic      [3:0]        nib_o,
	output logic                   nib_oe_o,
	input  wire logic              wr_n_i,
	input  wire logic              rd_n_i,
	input  wire logic              ce_n_i,
	output logic                   busy_o,
	input  wire logic              op_start_i,
	input  wire logic              op_block_i,
	input  wire logic              op_end_i,
	input  wire logic [7:0]        amp_i,
	input  wire logic              sample_valid_i,
	output logic                   store_en_o,
	output logic                   active_op_flag_o,
	output logic                   voice_wait_o,
	output logic                   rec_mode_o,
	output logic      [1:0]        cmd_mode_o,
	output logic      [1:0]        rate_o,
	output logic      [7:0]        phrase_o,
	output logic                   phrase_ok_o,
	output logic      [7:0]        block_value_o,
	output logic      [7:0]        block_count_o,
	output logic                   output_option_flag_o,
	output logic                   read_select_flag_o,
	output vrc_pkg::vrc_gain_t     gain_o,
	output logic      [3:0]        voice_level_o
);
	import vrc_pkg::*;

	localparam logic [13:0] BUSY_CMD   = 14'(`VRC_CYC(`VRC_T_CMD_NS));
	localparam logic [13:0] BUSY_RDCMD = 14'(`VRC_CYC(`VRC_T_RDCMD_NS));
	localparam logic [13:0] BUSY_DATA  = 14'(`VRC_CYC(`VRC_T_DATA_NS));
	localparam logic [13:0] BUSY_RST   = 14'(RESET_BUSY_CYC);

	if (PHRASES != 64 || RESET_BUSY_CYC < 1 || RESET_BUSY_CYC > 16383)
	begin : g_chk
		$error("vrc_cmd: unsupported PHRASES or RESET_BUSY_CYC");
	end

	// pin synchroniser {ce_n, rd_n, wr_n, nib}
	logic [6:0] s1_reg, s2_reg, s3_reg;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s1_reg <= 7'h70;
			s2_reg <= 7'h70;
			s3_reg <= 7'h70;
		end else begin
			s1_reg <= {ce_n_i, rd_n_i, wr_n_i, nib_i};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	logic [3:0] nib_s;
	logic       wr_ev, rd_ev, rd_act;
	assign nib_s  = s2_reg[3:0];
	assign wr_ev  = !s2_reg[4] && s3_reg[4] && !s2_reg[6];
	assign rd_ev  = !s2_reg[5] && s3_reg[5] && !s2_reg[6];
	assign rd_act = !s2_reg[5] && !s2_reg[6];

	// command group state
	vrc_state_t  state_reg, state_next;
	logic [13:0] busy_reg, busy_next;
	logic [3:0]  cmd_reg, cmd_next;
	logic [3:0]  need_reg, need_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [39:0] col_reg, col_next;
	logic [39:0] sh_reg, sh_next;
	logic [3:0]  out_reg, out_next;
	logic [1:0]  mode_reg, mode_next;
	logic [1:0]  rate_reg, rate_next;
	logic [7:0]  phrase_reg, phrase_next;
	logic [7:0]  blk_reg, blk_next;
	logic        rec_reg, rec_next;
	logic        opt_reg, opt_next;
	logic        rsel_reg, rsel_next;
	logic [3:0]  voice_reg, voice_next;
	vrc_gain_t   gain_reg, gain_next;
	logic        mem_we;
	logic [39:0] mem_rdata;
	// op group state
	logic        act_reg, act_next;
	logic        trig_reg, trig_next;
	logic [7:0]  bcnt_reg, bcnt_next;

	// block value and counter must address exactly the 256 RAM blocks
	if ((1 << $bits(blk_reg)) != `VRC_BLOCKS_TOTAL ||
		(1 << $bits(bcnt_reg)) != `VRC_BLOCKS_TOTAL) begin : g_blk_chk
		$error("vrc_cmd: block fields do not span the RAM blocks");
	end

	logic        idle_ok;
	assign idle_ok = (busy_reg == 14'h0000);

	// only the first reset edge judges whether a command was running;
	// later edges of a long pulse see the reset busy count instead
	logic        rst_seen_reg;
	always_ff @(posedge clk_sys_i) begin
		rst_seen_reg <= rst_i;
	end

	always_comb begin
		logic [3:0] d;
		d          = nib_s;
		state_next = state_reg;
		busy_next  = idle_ok ? busy_reg : busy_reg - 14'h0001;
		cmd_next   = cmd_reg;
		need_next  = need_reg;
		cnt_next   = cnt_reg;
		col_next   = col_reg;
		sh_next    = sh_reg;
		out_next   = out_reg;
		mode_next  = mode_reg;
		rate_next  = rate_reg;
		phrase_next = phrase_reg;
		blk_next   = blk_reg;
		rec_next   = rec_reg;
		opt_next   = opt_reg;
		rsel_next  = rsel_reg;
		voice_next = voice_reg;
		gain_next  = gain_reg;
		mem_we     = 1'b0;
		case (state_reg)
		ST_IDLE: begin
			if (rd_ev) begin
				out_next = {1'b1, voice_wait_o, act_reg, !idle_ok};
			end
			if (wr_ev && idle_ok) begin
				cmd_next  = nib_s;
				cnt_next  = 4'h0;
				col_next  = 40'h0;
				busy_next = BUSY_CMD;
				case (nib_s)
				`VRC_OP_RATE_MODE, `VRC_OP_FLAG_WR,
				`VRC_OP_VOICE, `VRC_OP_GAIN: begin
					need_next  = `VRC_NIB_SHORT;
					state_next = ST_COLLECT;
				end
				`VRC_OP_PHRASE, `VRC_OP_BLK_WR: begin
					need_next  = `VRC_NIB_BYTE;
					state_next = ST_COLLECT;
				end
				`VRC_OP_HDR_WR: begin
					if (mode_reg[1]) begin
						need_next  = `VRC_NIB_HDR;
						busy_next  = BUSY_RDCMD;
						state_next = ST_COLLECT;
					end
				end
				`VRC_OP_HDR_RD: begin
					if (mode_reg[1]) begin
						need_next  = `VRC_NIB_HDR;
						busy_next  = BUSY_RDCMD;
						state_next = ST_FETCH;
					end
				end
				`VRC_OP_STORED_RD: begin
					need_next  = `VRC_NIB_BYTE;
					busy_next  = BUSY_RDCMD;
					state_next = ST_FETCH;
				end
				`VRC_OP_LIVE_RD: begin
					need_next  = `VRC_NIB_BYTE;
					busy_next  = BUSY_RDCMD;
					sh_next    = {32'h0, bcnt_reg};
					state_next = ST_READOUT;
				end
				`VRC_OP_CAPTURE: rec_next = 1'b1;
				`VRC_OP_PLAY:    rec_next = 1'b0;
				default: ;
				endcase
			end
		end
		ST_COLLECT: begin
			if (wr_ev && idle_ok) begin
				col_next  = col_next_peek(col_reg, nib_s);
				cnt_next  = cnt_reg + 4'h1;
				busy_next = (cmd_reg == `VRC_OP_HDR_WR) ? BUSY_DATA
					: BUSY_CMD;
				if (cnt_reg + 4'h1 == need_reg) begin
					state_next = ST_IDLE;
					case (cmd_reg)
					`VRC_OP_RATE_MODE: begin
						if (d[`VRC_RATE_LSB+:2] != `VRC_RATE_BAD)
						begin
							rate_next = d[`VRC_RATE_LSB+:2];
							mode_next = d[`VRC_MODE_LSB+:2];
						end
					end
					`VRC_OP_FLAG_WR: begin
						opt_next  = d[`VRC_FLAG_OPT_BIT];
						rsel_next = d[`VRC_FLAG_RSEL_BIT];
					end
					`VRC_OP_VOICE: voice_next = d;
					`VRC_OP_GAIN: begin
						case (d[1:0])
						2'b10:   gain_next = GAIN_HALF;
						2'b11:   gain_next = GAIN_QUART;
						default: gain_next = GAIN_0DB;
						endcase
					end
					`VRC_OP_PHRASE: phrase_next = col_next[39:32];
					`VRC_OP_BLK_WR: blk_next = col_next[39:32];
					`VRC_OP_HDR_WR: mem_we = 1'b1;
					default: ;
					endcase
				end
			end
		end
		ST_FETCH: begin
			// header of the selected phrase; a stored read keeps only its low byte
			sh_next = (cmd_reg == `VRC_OP_HDR_RD) ? mem_rdata
				: {32'h0, mem_rdata[7:0]};
			state_next = ST_READOUT;
		end
		ST_READOUT: begin
			if (rd_ev && idle_ok) begin
				out_next  = sh_reg[3:0];
				sh_next   = {4'h0, sh_reg[39:4]};
				cnt_next  = cnt_reg + 4'h1;
				busy_next = BUSY_DATA;
				if (cnt_reg + 4'h1 == need_reg) begin
					state_next = ST_IDLE;
				end
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	function automatic logic [39:0] col_next_peek(input logic [39:0] c,
		input logic [3:0] n);
		return {n, c[39:4]};
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			busy_reg  <= BUSY_RST;
			cmd_reg   <= 4'h0;
			need_reg  <= 4'h0;
			cnt_reg   <= 4'h0;
			col_reg   <= 40'h0;
			sh_reg    <= 40'h0;
			out_reg   <= 4'h0;
			opt_reg   <= 1'b0;
			rsel_reg  <= 1'b0;
			voice_reg <= `VRC_VOICE_OFF;
			gain_reg  <= GAIN_0DB;
			// mode, rate, phrase, block and rec survive a reset taken while idle, unless por_i is high; flags, gain, voice clear
			if (por_i || (!rst_seen_reg &&
				(state_reg != ST_IDLE || !idle_ok))) begin
				mode_reg   <= `VRC_MODE_REC;
				rate_reg   <= 2'h0;
				phrase_reg <= `VRC_PHRASE_ZERO;
				blk_reg    <= 8'h00;
				rec_reg    <= 1'b0;
			end
		end else begin
			state_reg  <= state_next;
			busy_reg   <= busy_next;
			cmd_reg    <= cmd_next;
			need_reg   <= need_next;
			cnt_reg    <= cnt_next;
			col_reg    <= col_next;
			sh_reg     <= sh_next;
			out_reg    <= out_next;
			mode_reg   <= mode_next;
			rate_reg   <= rate_next;
			phrase_reg <= phrase_next;
			blk_reg    <= blk_next;
			rec_reg    <= rec_next;
			opt_reg    <= opt_next;
			rsel_reg   <= rsel_next;
			voice_reg  <= voice_next;
			gain_reg   <= gain_next;
		end
	end

	vrc_hdr_mem #(.W(40), .DEPTH(PHRASES), .AW(6)) u_hdr (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.we_i      (mem_we),
		.waddr_i   (phrase_reg[5:0]),
		.wdata_i   (col_next),
		.raddr_i   (phrase_reg[5:0]),
		.rdata_o   (mem_rdata)
	);

	// operation tracking: active flag, block counter, voice trigger
	logic [7:0] thr;
	logic       loud;
	assign thr  = {voice_reg, 4'h0};
	assign loud = sample_valid_i && (amp_i > thr);

	always_comb begin
		act_next  = act_reg;
		trig_next = trig_reg;
		bcnt_next = bcnt_reg;
		if (op_start_i) begin
			act_next  = 1'b1;
			trig_next = 1'b0;
			bcnt_next = `VRC_BLOCK_FIRST;
		end else if (act_reg) begin
			if (op_block_i) begin
				bcnt_next = bcnt_reg + 8'h01;
			end
			if (rec_reg && loud) begin
				trig_next = 1'b1;
			end
			if (op_end_i) begin
				act_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			act_reg  <= 1'b0;
			trig_reg <= 1'b0;
			bcnt_reg <= 8'h00;
		end else begin
			act_reg  <= act_next;
			trig_reg <= trig_next;
			bcnt_reg <= bcnt_next;
		end
	end

	assign voice_wait_o = act_reg && rec_reg &&
		voice_reg != `VRC_VOICE_OFF && !trig_reg;
	assign store_en_o = act_reg && rec_reg && sample_valid_i &&
		(!voice_wait_o || loud);

	always_comb begin
		case (mode_reg)
		`VRC_MODE_REC: phrase_ok_o = phrase_reg != `VRC_PHRASE_ZERO &&
			phrase_reg <= `VRC_PHRASE_RAM_MAX;
		`VRC_MODE_ROM: phrase_ok_o = phrase_reg != `VRC_PHRASE_ZERO;
		default:       phrase_ok_o = phrase_reg <= `VRC_PHRASE_RAM_MAX;
		endcase
	end

	assign nib_o                = out_reg;
	assign nib_oe_o             = rd_act;
	assign busy_o               = !idle_ok || state_reg == ST_FETCH;
	assign active_op_flag_o     = act_reg;
	assign rec_mode_o           = rec_reg;
	assign cmd_mode_o           = mode_reg;
	assign rate_o               = rate_reg;
	assign phrase_o             = phrase_reg;
	assign block_value_o        = blk_reg;
	assign block_count_o        = bcnt_reg;
	assign output_option_flag_o = opt_reg;
	assign read_select_flag_o   = rsel_reg;
	assign gain_o               = gain_reg;
	assign voice_level_o        = voice_reg;
endmodule // vrc_cmd

// *** hw/vrc_hdr_mem.sv ***
// Purpose: per-phrase 40-bit header store
// Assumes: one write and one read port on the system clock
// Notes: contents are never cleared by reset
`timescale 1ns/1ns
module vrc_hdr_mem #(
	parameter int W     = 40,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          clk_sys_i,
	input  wire logic          rst_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [W-1:0]  wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [W-1:0]  rdata_o
);
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rdata_reg;

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("vrc_hdr_mem: DEPTH exceeds address range");
	end

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= mem[raddr_i];
		end
	end

	assign rdata_o = rdata_reg;
endmodule // vrc_hdr_mem

// *** hw/vrc_pkg.sv ***
// Purpose: types of the voice recorder condition command block
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in vrc_cfg.svh
package vrc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_COLLECT = 2'b01,
		ST_FETCH   = 2'b10,
		ST_READOUT = 2'b11
	} vrc_state_t;

	typedef enum logic [1:0] {
		GAIN_0DB   = 2'b00,
		GAIN_HALF  = 2'b01,
		GAIN_QUART = 2'b10
	} vrc_gain_t;

endpackage

// *** verif/test_voice_recorder_condition_cmds.sv ***
// Purpose: self-checking bench of the condition command block
// Assumes: host model paces every access on the busy pin
// Notes: reset busy time shortened to 20 cycles
`timescale 1ns/1ns
module test_voice_recorder_condition_cmds;
	import vrc_pkg::*;
	logic        clk_sys_i, rst_i, por_i, wr_n_i, rd_n_i, ce_n_i, busy_o;
	logic [3:0]  nib_i, nib_o, voice_level_o, cur, n, lo;
	logic        nib_oe_o, op_start_i, op_block_i, op_end_i, sample_valid_i;
	logic [7:0]  amp_i, phrase_o, block_value_o, block_count_o;
	logic        store_en_o, active_op_flag_o, voice_wait_o, rec_mode_o;
	logic        phrase_ok_o, output_option_flag_o, read_select_flag_o;
	logic [1:0]  cmd_mode_o, rate_o;
	vrc_gain_t   gain_o;
	int          miscompares, n_checks, seed, pend, ws, sel_q[$];
	logic [7:0]  exp_q[$], rdv, cph, b, we;
	logic [39:0] h, hr;

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	vrc_cmd #(.RESET_BUSY_CYC(20)) u_vrc_cmd (.clk_sys_i, .rst_i, .por_i,
		.nib_i, .nib_o, .nib_oe_o, .wr_n_i, .rd_n_i, .ce_n_i, .busy_o,
		.op_start_i, .op_block_i, .op_end_i, .amp_i, .sample_valid_i,
		.store_en_o, .active_op_flag_o, .voice_wait_o, .rec_mode_o,
		.cmd_mode_o, .rate_o, .phrase_o, .phrase_ok_o, .block_value_o,
		.block_count_o, .output_option_flag_o, .read_select_flag_o,
		.gain_o, .voice_level_o);

	vrc_host u_host (.clk_sys_i, .busy_i(busy_o), .nib_i(nib_o),
		.nib_o(nib_i), .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .ce_n_o(ce_n_i));

	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		n_checks++;
		if (got !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, e);
		end
	endtask

	initial forever begin
		wait (pend > 0);
		ws = sel_q.pop_front();
		we = exp_q.pop_front();
		case (ws)
			0: chk(8'({cmd_mode_o, rate_o}), we);
			1: chk(phrase_o, we);
			2: chk(8'(phrase_ok_o), we);
			3: chk(block_value_o, we);
			4: chk(8'(gain_o), we);
			5: chk(8'({read_select_flag_o, output_option_flag_o}), we);
			6: chk(block_count_o, we);
			7: chk(8'(active_op_flag_o), we);
			8: chk(8'(store_en_o), we);
			9: chk(8'(rec_mode_o), we);
			default: chk(rdv, we);
		endcase
		pend--;
	end

	task automatic ex(input int s, input logic [7:0] e);
		@(posedge clk_sys_i);
		#1;
		sel_q.push_back(s);
		exp_q.push_back(e);
		pend++;
		wait (pend == 0);
	endtask

	task automatic cw(input logic [3:0] op, input logic [3:0] d);
		u_host.wr(op);
		u_host.wr(d);
	endtask

	task automatic ph(input logic [7:0] p);
		u_host.wr(4'h7);
		u_host.wr(p[3:0]);
		ex(1, cph);
		u_host.wr(p[7:4]);
		cph = p;
		ex(1, p);
		ex(2, 8'((p != 8'h00) && (cur[2] || p <= 8'h3F)));
	endtask

	task automatic go(input logic [2:0] p);
		@(posedge clk_sys_i);
		{op_start_i, op_block_i, op_end_i} <= p;
		@(posedge clk_sys_i);
		{op_start_i, op_block_i, op_end_i} <= 3'b000;
	endtask

	task automatic samp(input logic [7:0] a, input logic e);
		@(posedge clk_sys_i);
		amp_i <= a;
		sample_valid_i <= 1'b1;
		ex(8, 8'(e));
		@(posedge clk_sys_i);
		sample_valid_i <= 1'b0;
	endtask

	task automatic rb();
		u_host.rd(lo);
		u_host.rd(n);
		rdv = {n, lo};
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// limit set well above the expected run of about 33000 cycles
	initial begin
		#(100 * 90000);
		miscompares++;
		final_report();
	end

	initial begin
		seed = 59788;
		{miscompares, n_checks, pend} = 0;
		{rst_i, por_i} = 2'b11;
		{op_start_i, op_block_i, op_end_i, sample_valid_i} = 4'h0;
		amp_i = 8'h00;
		cph = 8'h00;
		cur = 4'h0;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		u_host.idle();
		for (int i = 0; i < 8; i++) begin
			n = 4'(i) & 4'h7;
			cw(4'h6, n);
			if (n[1:0] != 2'h3)
				cur = n;
			ex(0, 8'(cur));
		end
		$display("rate and mode done");
		ph(8'h00);
		ph(8'hFF);
		cw(4'h6, 4'h0);
		cur = 4'h0;
		ph(8'h3F);
		ph(8'h40);
		ph(8'($random(seed)));
		ph(8'h25);
		b = 8'($random(seed));
		u_host.wr(4'hA);
		u_host.wr(b[3:0]);
		u_host.wr(b[7:4]);
		ex(3, b);
		cw(4'hD, 4'h3);
		ex(5, 8'h03);
		cw(4'hE, 4'h3);
		$display("phrase and block done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		u_host.idle();
		ex(0, 8'(cur));
		ex(1, cph);
		ex(3, b);
		ex(5, 8'h00);
		ex(4, 8'h00);
		$display("reset while idle done");
		cw(4'h5, 4'h2);
		u_host.wr(4'h3);
		ex(9, 8'h01);
		go(3'b100);
		ex(7, 8'h01);
		ex(6, 8'h01);
		repeat (3) go(3'b010);
		ex(6, 8'h04);
		samp(8'h10, 1'b0);
		samp(8'h20, 1'b0);
		samp(8'h21, 1'b1);
		samp(8'h00, 1'b1);
		for (int g = 0; g < 4; g++) begin
			cw(4'hE, 4'(g));
			ex(4, (g < 2) ? 8'h00 : 8'(g - 1));
		end
		ex(7, 8'h01);
		go(3'b001);
		ex(7, 8'h00);
		ex(6, 8'h04);
		cw(4'hD, 4'h2);
		u_host.wr(4'hC);
		rb();
		ex(10, 8'h04);
		$display("data path done");
		cw(4'h6, 4'h8);
		h = {32'($random(seed)), 8'($random(seed))};
		u_host.wr(4'h8);
		for (int i = 0; i < 10; i++)
			u_host.wr(h[i*4 +: 4]);
		u_host.wr(4'h9);
		for (int i = 0; i < 10; i++) begin
			u_host.rd(n);
			hr[i*4 +: 4] = n;
		end
		for (int i = 0; i < 5; i++) begin
			rdv = hr[i*8 +: 8];
			ex(10, h[i*8 +: 8]);
		end
		cw(4'h6, 4'h0);
		cw(4'hD, 4'h0);
		u_host.wr(4'hB);
		rb();
		ex(10, h[7:0]);
		u_host.rd(n);
		rdv = 8'(n);
		ex(10, 8'h08);
		{rst_i, por_i} <= 2'b11;
		repeat (2) @(posedge clk_sys_i);
		{rst_i, por_i} <= 2'b00;
		u_host.idle();
		ex(1, 8'h00);
		ex(9, 8'h00);
		$display("header and counts done");
		final_report();
	end
endmodule // test_voice_recorder_condition_cmds

// *** verif/vrc_cmd_props.sv ***
// Purpose: concurrent checks on the condition command block ports
// Assumes: single clock domain, reset synchronous active high
// Notes: voice threshold is level times 16
`timescale 1ns/1ns
module vrc_cmd_props (
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	input  wire logic               rd_n_i,
	input  wire logic               ce_n_i,
	input  wire logic               nib_oe_o,
	input  wire logic               op_start_i,
	input  wire logic               op_block_i,
	input  wire logic               op_end_i,
	input  wire logic [7:0]         amp_i,
	input  wire logic               sample_valid_i,
	input  wire logic               store_en_o,
	input  wire logic               active_op_flag_o,
	input  wire logic               voice_wait_o,
	input  wire logic               rec_mode_o,
	input  wire logic [1:0]         rate_o,
	input  wire logic [7:0]         block_count_o,
	input  wire vrc_pkg::vrc_gain_t gain_o,
	input  wire logic [3:0]         voice_level_o
);
	import vrc_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_run_start;
		op_start_i ##1 active_op_flag_o;
	endsequence

	sequence s_loud_sample;
		active_op_flag_o && rec_mode_o && voice_wait_o && sample_valid_i
		&& !op_start_i && !op_end_i && (amp_i > {voice_level_o, 4'h0});
	endsequence

	a_start_sets_active: assert property (
		op_start_i |=> active_op_flag_o)
		else $error("active flag not set by start");
	a_start_counts_one: assert property (
		s_run_start |-> block_count_o == 8'h01)
		else $error("block counter not 01 at start");
	a_active_holds: assert property (
		active_op_flag_o && !op_end_i |=> active_op_flag_o)
		else $error("active flag dropped early");
	a_block_steps: assert property (
		active_op_flag_o && op_block_i && !op_start_i
		|=> block_count_o == $past(block_count_o) + 8'h01)
		else $error("block counter did not step");
	a_idle_count_kept: assert property (
		!op_start_i && !active_op_flag_o |=> $stable(block_count_o))
		else $error("block counter moved while idle");
	a_rate_legal: assert property (
		rate_o != 2'h3)
		else $error("refused rate stored");
	a_voice_holdoff: assert property (
		active_op_flag_o && rec_mode_o && voice_wait_o &&
		!(sample_valid_i && amp_i > {voice_level_o, 4'h0}) |-> !store_en_o)
		else $error("sample stored before trigger");
	a_loud_stored: assert property (
		s_loud_sample |-> store_en_o)
		else $error("triggering sample not stored");
	a_oe_follows: assert property (
		nib_oe_o == (!$past(rd_n_i, 2) && !$past(ce_n_i, 2)))
		else $error("data output enable not tracking read strobe");
	a_store_all_after: assert property (
		active_op_flag_o && rec_mode_o && !voice_wait_o && sample_valid_i
		|-> store_en_o)
		else $error("sample dropped after trigger");
	a_trigger_fires: assert property (
		s_loud_sample |=> !voice_wait_o)
		else $error("loud sample did not trigger");
	a_reset_gain: assert property (
		$fell(rst_i) |-> gain_o == GAIN_0DB)
		else $error("gain not 0 dB after reset");
endmodule // vrc_cmd_props

bind vrc_cmd vrc_cmd_props u_props (.clk_sys_i, .rst_i, .rd_n_i, .ce_n_i,
	.nib_oe_o, .op_start_i,
	.op_block_i, .op_end_i, .amp_i, .sample_valid_i, .store_en_o,
	.active_op_flag_o, .voice_wait_o, .rec_mode_o, .rate_o, .block_count_o,
	.gain_o, .voice_level_o);

// *** verif/vrc_host.sv ***
// Purpose: host controller model on the nibble bus
// Assumes: strobes held long enough for the 2-flop synchronisers
// Notes: data lines carry the inverted last nibble when not written
`timescale 1ns/1ns
module vrc_host (
	input  wire logic       clk_sys_i,
	input  wire logic       busy_i,
	input  wire logic [3:0] nib_i,
	output logic      [3:0] nib_o,
	output logic            wr_n_o,
	output logic            rd_n_o,
	output logic            ce_n_o
);
	initial begin
		nib_o = 4'h0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		ce_n_o = 1'b1;
	end

	task automatic idle();
		int k;
		k = 0;
		@(posedge clk_sys_i);
		while (busy_i !== 1'b0 && k < 4000) begin
			@(posedge clk_sys_i);
			k++;
		end
	endtask

	task automatic wr(input logic [3:0] d);
		idle();
		nib_o <= d;
		ce_n_o <= 1'b0;
		@(posedge clk_sys_i);
		wr_n_o <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		wr_n_o <= 1'b1;
		@(posedge clk_sys_i);
		ce_n_o <= 1'b1;
		nib_o <= ~d;
		repeat (4) @(posedge clk_sys_i);
		idle();
	endtask

	task automatic rd(output logic [3:0] d);
		idle();
		ce_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		d = nib_i;
		rd_n_o <= 1'b1;
		ce_n_o <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
	endtask
endmodule // vrc_host
